// file: sbci_pkg.sv
// Constants, encodings and helpers shared by the SDRAM command interface files
package sbci_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int LANE_W = 8;
  localparam int ADDR_W = 12;
  localparam int COL_W = 9;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int MODE_W = 14;
  localparam int AP_BIT = 10;
  // Low row bits kept in the model array; higher rows alias onto them
  localparam int ROW_USE = 1;
  localparam int MEM_AW = BANK_W + ROW_USE + COL_W;
  localparam int FIFO_DEPTH = 16;
  localparam int WBUF_W = MEM_AW + DATA_W + LANES;
  localparam int CL_MAX = 3;

  ////////////////////////////////////////////////////////////////////////////////
  // Mode register field positions and reset value
  localparam int M_BL_LO = 0;
  localparam int M_BL_HI = 2;
  localparam int M_BT = 3;
  localparam int M_CL_LO = 4;
  localparam int M_CL_HI = 6;
  localparam int M_OP_LO = 7;
  localparam int M_OP_HI = 8;
  localparam int M_WB = 9;
  localparam logic [MODE_W-1:0] MODE_RST = 14'h0020;

  // Burst length codes and the matching last beat index
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FULL = 3'h7;
  localparam logic [COL_W-1:0] LAST_1 = 9'h000;
  localparam logic [COL_W-1:0] LAST_2 = 9'h001;
  localparam logic [COL_W-1:0] LAST_4 = 9'h003;
  localparam logic [COL_W-1:0] LAST_8 = 9'h007;
  localparam logic [COL_W-1:0] LAST_FULL = 9'h1FF;
  localparam logic [COL_W-1:0] COL_ONE = 9'h001;

  // Read latency codes
  localparam logic [2:0] CL_1 = 3'h1;
  localparam logic [2:0] CL_2 = 3'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Command code is {row strobe, column strobe, write enable}, all active low
  typedef enum logic [2:0] {
    CMD_LMR = 3'h0,
    CMD_REF = 3'h1,
    CMD_PRE = 3'h2,
    CMD_ACT = 3'h3,
    CMD_WR = 3'h4,
    CMD_RD = 3'h5,
    CMD_BST = 3'h6,
    CMD_NOP = 3'h7
  } sbci_cmd_e;

  typedef enum logic [2:0] {
    PM_RUN = 3'h0,
    PM_SUSPEND = 3'h1,
    PM_PDN_PRE = 3'h2,
    PM_PDN_ACT = 3'h3,
    PM_SELF = 3'h4
  } sbci_pm_e;

  // Last beat index for a burst length code; reserved codes act as one beat
  function automatic logic [COL_W-1:0] sbci_burst_last(input logic [2:0] code);
    case (code)
      BL_1: return LAST_1;
      BL_2: return LAST_2;
      BL_4: return LAST_4;
      BL_8: return LAST_8;
      BL_FULL: return LAST_FULL;
      default: return LAST_1;
    endcase
  endfunction

endpackage

// file: sbci_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sbci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW:0] wr_ptr;
  logic [PW:0] rd_ptr;
  logic [PW:0] next_wr_ptr;
  logic [PW:0] next_rd_ptr;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr[PW] != rd_ptr[PW]) && (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = store[rd_ptr[PW-1:0]];

  // Pointer advance
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (in_valid_i && !full) begin
      next_wr_ptr = wr_ptr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // Storage needs no reset; empty guards stale words
  always_ff @(posedge clk_sys_i) begin
    if (in_valid_i && !full) begin
      store[wr_ptr[PW-1:0]] <= in_data_i;
    end
  end
endmodule

// file: sbci_mem.sv
// Byte-writable single-port array with registered read data
`timescale 1ns/1ps
module sbci_mem #(
  parameter int AW = 12,
  parameter int LANES = 4,
  parameter int LANE_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic write_i,
  input wire logic [LANES-1:0] byte_en_i,
  input wire logic [LANES*LANE_W-1:0] wdata_i,
  output logic [LANES*LANE_W-1:0] rdata_o
);
  // One narrow array per byte lane
  for (genvar g = 0; g < LANES; g++) begin : gen_lane
    logic [LANE_W-1:0] ram [2**AW];
    always_ff @(posedge clk_sys_i) begin
      if (write_i && byte_en_i[g]) begin
        ram[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
      end
      rdata_o[g*LANE_W +: LANE_W] <= ram[addr_i];
    end
  end
endmodule

// file: sbci_sdram_if.sv
// Device-side pin interface of a four-bank SDRAM: commands, masks and data
`timescale 1ns/1ps
// What this block does
// - Register all pins on rising clock edge
// - Clock advances burst counter and output registers
// - Clock enable low picks power-down, refresh, suspend
// - Clock enable asynchronous while powered down
// - Input buffers frozen in power-down, self refresh
// - Chip select high masks every command
// - Command from select and three strobes together
// - Write mask high drops that byte
// - Read mask high floats byte two clocks later
// - Mask bit n covers byte lane n
// - Bank bits pick target bank, carry op-code
// - Activate latches row, read/write latch column
// - Address bit ten requests auto precharge
// - Precharge all banks or only selected bank
// - Mode load takes address and bank bits
// - Mode fields: length, type, latency, mode, write
module sbci_sdram_if (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic clk_enable_pin_i,
  input wire logic chip_sel_n_i,
  input wire logic row_strobe_n_i,
  input wire logic col_strobe_n_i,
  input wire logic write_en_n_i,
  input wire logic bank_sel_bit0_i,
  input wire logic bank_sel_bit1_i,
  input wire logic [sbci_pkg::ADDR_W-1:0] row_col_address_i,
  input wire logic [sbci_pkg::LANES-1:0] byte_mask_lanes_i,
  input wire logic [sbci_pkg::DATA_W-1:0] data_bus_32_i,
  output logic [sbci_pkg::DATA_W-1:0] data_bus_32_o,
  output logic [sbci_pkg::LANES-1:0] data_bus_32_oe_n_o,
  output logic [2:0] power_mode_o,
  output logic [sbci_pkg::MODE_W-1:0] mode_reg_o,
  output logic [sbci_pkg::BANKS-1:0] bank_open_o,
  output logic wr_buf_ready_o
);
  import sbci_pkg::*;

  localparam int IN_W = 1 + 3 + BANK_W + ADDR_W + LANES + DATA_W;
  localparam logic [IN_W-1:0] IN_RST = {1'b1, CMD_NOP, {(IN_W-4){1'b0}}};

  ////////////////////////////////////////////////////////////////////////////////
  // Pin capture
  logic [IN_W-1:0] in_q;
  logic [IN_W-1:0] next_in;
  logic cke_q;
  logic next_cke_q;
  logic cke_s1;
  logic cke_s2;
  logic [LANES-1:0] mask_d1;
  logic cs_n_q;
  logic [2:0] cmd_bits;
  sbci_cmd_e cmd_q;
  logic [BANK_W-1:0] bank_q;
  logic [ADDR_W-1:0] addr_q;
  logic [LANES-1:0] mask_q;
  logic [DATA_W-1:0] wdat_q;
  sbci_pm_e pm;
  sbci_pm_e next_pm;
  logic in_en;

  assign {cs_n_q, cmd_bits, bank_q, addr_q, mask_q, wdat_q} = in_q;
  assign cmd_q = sbci_cmd_e'(cmd_bits);
  // Buffers off in power-down and self refresh to save standby current
  assign in_en = (pm == PM_RUN) || (pm == PM_SUSPEND);

  // Sample pins on the rising edge; command is select plus three strobes
  always_comb begin
    next_in = in_q;
    if (in_en) begin
      next_in = {chip_sel_n_i, row_strobe_n_i, col_strobe_n_i, write_en_n_i,
                 bank_sel_bit1_i, bank_sel_bit0_i, row_col_address_i,
                 byte_mask_lanes_i, data_bus_32_i};
    end
    // While down the enable is taken through the synchroniser instead
    next_cke_q = in_en ? clk_enable_pin_i : cke_s2;
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      in_q <= IN_RST;
      cke_q <= 1'b1;
      cke_s1 <= 1'b0;
      cke_s2 <= 1'b0;
      mask_d1 <= '0;
    end else begin
      in_q <= next_in;
      cke_q <= next_cke_q;
      cke_s1 <= clk_enable_pin_i;
      cke_s2 <= cke_s1;
      mask_d1 <= mask_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode
  logic run;
  logic cmd_ok;
  logic is_act;
  logic is_rd;
  logic is_wr;
  logic is_pre;
  logic is_lmr;
  logic is_bst;
  logic all_idle;
  logic [BANKS-1:0] bank_open;
  logic [ADDR_W-1:0] bank_row [BANKS];
  logic [MODE_W-1:0] mode_reg;
  logic [MODE_W-1:0] next_mode;

  // Decoder only listens while the internal clock runs and select is low
  assign run = (pm == PM_RUN) && cke_q;
  assign cmd_ok = run && !cs_n_q;
  assign is_act = cmd_ok && (cmd_q == CMD_ACT);
  assign is_rd = cmd_ok && (cmd_q == CMD_RD);
  assign is_wr = cmd_ok && (cmd_q == CMD_WR);
  assign is_pre = cmd_ok && (cmd_q == CMD_PRE);
  assign is_lmr = cmd_ok && (cmd_q == CMD_LMR);
  assign is_bst = cmd_ok && (cmd_q == CMD_BST);
  assign all_idle = (bank_open == '0);

  // Mode load only honoured with every bank idle
  always_comb begin
    next_mode = mode_reg;
    if (is_lmr && all_idle) begin
      next_mode = {bank_q, addr_q};
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mode_reg <= MODE_RST;
    end else begin
      mode_reg <= next_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Burst engine
  logic b_active;
  logic b_write;
  logic b_ap;
  logic [BANK_W-1:0] b_bank;
  logic [COL_W-1:0] b_start;
  logic [COL_W-1:0] b_cnt;
  logic [COL_W-1:0] b_last;
  logic next_b_active;
  logic next_b_write;
  logic next_b_ap;
  logic [BANK_W-1:0] next_b_bank;
  logic [COL_W-1:0] next_b_start;
  logic [COL_W-1:0] next_b_cnt;
  logic [COL_W-1:0] next_b_last;
  logic start;
  logic cont;
  logic beat;
  logic beat_write;
  logic [BANK_W-1:0] beat_bank;
  logic [COL_W-1:0] beat_col;
  logic [COL_W-1:0] start_last;
  logic ap_close;
  logic [COL_W-1:0] mode_last;

  // Column inside the wrap block: sequential adds, interleaved flips
  function automatic logic [COL_W-1:0] beat_col_f(input logic [COL_W-1:0] s,
      input logic [COL_W-1:0] c, input logic [COL_W-1:0] lm, input logic il);
    logic [COL_W-1:0] off;
    off = il ? (s ^ c) : COL_W'(s + c);
    return (s & ~lm) | (off & lm);
  endfunction

  // Reads and writes to a closed bank are ignored
  assign start = (is_rd || is_wr) && bank_open[bank_q];
  assign cont = run && b_active && !start && !is_bst;
  assign beat = start || cont;
  assign beat_write = start ? is_wr : b_write;
  assign beat_bank = start ? bank_q : b_bank;
  assign mode_last = sbci_burst_last(mode_reg[M_BL_HI:M_BL_LO]);
  // Single-location write mode shortens write bursts to one beat
  assign start_last = (is_wr && mode_reg[M_WB]) ? LAST_1 : mode_last;
  assign beat_col = start ? addr_q[COL_W-1:0] :
                    beat_col_f(b_start, b_cnt, b_last, mode_reg[M_BT]);
  assign ap_close = (start && (start_last == LAST_1) && addr_q[AP_BIT]) ||
                    (cont && (b_cnt == b_last) && b_ap);

  // Counter steps once per running clock; a new access cuts the old one
  always_comb begin
    next_b_active = b_active;
    next_b_write = b_write;
    next_b_ap = b_ap;
    next_b_bank = b_bank;
    next_b_start = b_start;
    next_b_cnt = b_cnt;
    next_b_last = b_last;
    if (start) begin
      next_b_active = (start_last != LAST_1);
      next_b_write = is_wr;
      next_b_ap = addr_q[AP_BIT];
      next_b_bank = bank_q;
      next_b_start = addr_q[COL_W-1:0];
      next_b_cnt = COL_ONE;
      next_b_last = start_last;
    end else if (cont) begin
      if (b_cnt == b_last) begin
        next_b_active = 1'b0;
      end else begin
        next_b_cnt = b_cnt + COL_ONE;
      end
    end else if (is_bst) begin
      next_b_active = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      b_active <= 1'b0;
      b_write <= 1'b0;
      b_ap <= 1'b0;
      b_bank <= '0;
      b_start <= '0;
      b_cnt <= '0;
      b_last <= '0;
    end else begin
      b_active <= next_b_active;
      b_write <= next_b_write;
      b_ap <= next_b_ap;
      b_bank <= next_b_bank;
      b_start <= next_b_start;
      b_cnt <= next_b_cnt;
      b_last <= next_b_last;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-bank row state
  for (genvar g = 0; g < BANKS; g++) begin : gen_bank
    logic open_r;
    logic next_open;
    logic [ADDR_W-1:0] row_r;
    logic [ADDR_W-1:0] next_row;
    always_comb begin
      next_open = open_r;
      next_row = row_r;
      if (is_act && (bank_q == BANK_W'(g))) begin
        next_open = 1'b1;
        next_row = addr_q;
      end
      if (is_pre && (addr_q[AP_BIT] || (bank_q == BANK_W'(g)))) begin
        next_open = 1'b0;
      end
      if (ap_close && (beat_bank == BANK_W'(g))) begin
        next_open = 1'b0;
      end
    end
    always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
        open_r <= 1'b0;
        row_r <= '0;
      end else begin
        open_r <= next_open;
        row_r <= next_row;
      end
    end
    assign bank_open[g] = open_r;
    assign bank_row[g] = row_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power state: what a low clock enable means depends on current activity
  always_comb begin
    next_pm = pm;
    case (pm)
      PM_RUN: begin
        if (!cke_q) begin
          if (!cs_n_q && (cmd_q == CMD_REF) && all_idle) begin
            next_pm = PM_SELF;
          end else if (b_active) begin
            next_pm = PM_SUSPEND;
          end else if (!all_idle) begin
            next_pm = PM_PDN_ACT;
          end else begin
            next_pm = PM_PDN_PRE;
          end
        end
      end
      PM_SUSPEND: begin
        if (cke_q) begin
          next_pm = PM_RUN;
        end
      end
      PM_PDN_PRE, PM_PDN_ACT, PM_SELF: begin
        if (cke_s2) begin
          next_pm = PM_RUN;
        end
      end
      default: next_pm = PM_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pm <= PM_RUN;
    end else begin
      pm <= next_pm;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Write buffer and array; reads own the port, writes drain in the gaps
  logic wr_push;
  logic wb_in_ready;
  logic wb_out_valid;
  logic wb_out_ready;
  logic [WBUF_W-1:0] wb_out;
  logic [MEM_AW-1:0] beat_addr;
  logic [LANES-1:0] wb_in_be;
  logic rd_beat;
  logic [DATA_W-1:0] mem_rdata;
  logic wbuf_rdy_q;

  // Limitation: a read that hits a still-buffered write returns stale data
  assign beat_addr = {beat_bank, bank_row[beat_bank][ROW_USE-1:0], beat_col};
  assign wr_push = beat && beat_write;
  assign wb_in_be = ~mask_q;
  assign rd_beat = beat && !beat_write;
  assign wb_out_ready = !rd_beat;

  sbci_fifo #(
    .WIDTH(WBUF_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .in_valid_i(wr_push),
    .in_ready_o(wb_in_ready),
    .in_data_i({beat_addr, wdat_q, wb_in_be}),
    .out_valid_o(wb_out_valid),
    .out_ready_i(wb_out_ready),
    .out_data_o(wb_out)
  );

  sbci_mem #(
    .AW(MEM_AW),
    .LANES(LANES),
    .LANE_W(LANE_W)
  ) u_mem (
    .clk_sys_i(clk_sys_i),
    .addr_i(rd_beat ? beat_addr : wb_out[WBUF_W-1 -: MEM_AW]),
    .write_i(wb_out_valid && wb_out_ready),
    .byte_en_i(wb_out[LANES-1:0]),
    .wdata_i(wb_out[LANES +: DATA_W]),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read latency line and output registers
  logic rv1;
  logic [DATA_W:0] lat_d [CL_MAX-1];
  logic [DATA_W:0] tap;
  logic [DATA_W-1:0] next_out;
  logic [LANES-1:0] next_oe_n;
  logic [2:0] cl;

  assign cl = mode_reg[M_CL_HI:M_CL_LO];

  // Unlisted latency codes fall back to the longest tap
  always_comb begin
    case (cl)
      CL_1: tap = {rv1, mem_rdata};
      CL_2: tap = lat_d[0];
      default: tap = lat_d[1];
    endcase
    next_out = tap[DATA_W-1:0];
    // Mask seen two edges earlier floats its lane whatever the data
    next_oe_n = ~({LANES{tap[DATA_W]}} & ~mask_d1);
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rv1 <= 1'b0;
      lat_d[0] <= '0;
      lat_d[1] <= '0;
      data_bus_32_o <= '0;
      data_bus_32_oe_n_o <= '1;
      wbuf_rdy_q <= 1'b1;
    end else begin
      rv1 <= rd_beat;
      lat_d[0] <= {rv1, mem_rdata};
      lat_d[1] <= lat_d[0];
      data_bus_32_o <= next_out;
      data_bus_32_oe_n_o <= next_oe_n;
      wbuf_rdy_q <= wb_in_ready;
    end
  end

  assign power_mode_o = pm;
  assign mode_reg_o = mode_reg;
  assign bank_open_o = bank_open;
  assign wr_buf_ready_o = wbuf_rdy_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  sequence s_idle_stop;
    run == 1'b0 && pm == PM_RUN && !b_active && all_idle && (cs_n_q || cmd_q != CMD_REF);
  endsequence
  sequence s_ap_single;
    start && addr_q[AP_BIT] && (start_last == LAST_1);
  endsequence

  property p_cs_mask;
    cs_n_q && !b_active |=> bank_open == $past(bank_open) && mode_reg == $past(mode_reg);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken with select high");
  property p_act_row;
    is_act |=> bank_open[$past(bank_q)] && bank_row[$past(bank_q)] == $past(addr_q);
  endproperty
  a_act_row: assert property (p_act_row) else $error("activate row not latched");
  property p_pre_all;
    is_pre && addr_q[AP_BIT] |=> bank_open == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");
  property p_pre_one;
    is_pre && !addr_q[AP_BIT] && !is_act |=> !bank_open[$past(bank_q)];
  endproperty
  a_pre_one: assert property (p_pre_one) else $error("bank precharge missed");
  property p_lmr;
    is_lmr && all_idle |=> mode_reg == $past({bank_q, addr_q});
  endproperty
  a_lmr: assert property (p_lmr) else $error("mode load lost op-code");
  property p_rd_mask;
    mask_q[0] |-> ##2 data_bus_32_oe_n_o[0];
  endproperty
  a_rd_mask: assert property (p_rd_mask) else $error("masked lane driven");
  property p_wr_mask;
    wr_push && !wb_out_valid |=> wb_out_valid && wb_out[LANES-1:0] == ~$past(mask_q);
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("masked byte written");
  property p_burst_cnt;
    cont && b_cnt != b_last |=> b_cnt == $past(b_cnt) + COL_ONE;
  endproperty
  a_burst_cnt: assert property (p_burst_cnt) else $error("burst counter stalled");
  property p_ap;
    s_ap_single |=> !bank_open[$past(bank_q)];
  endproperty
  a_ap: assert property (p_ap) else $error("auto precharge missed");
  property p_enter;
    s_idle_stop |=> pm == PM_PDN_PRE ##1 (pm == PM_PDN_PRE || pm == PM_RUN);
  endproperty
  a_enter: assert property (p_enter) else $error("idle stop not power-down");
  property p_exit;
    !in_en && cke_s2 |=> pm == PM_RUN;
  endproperty
  a_exit: assert property (p_exit) else $error("power-down exit missed");
  property p_frozen;
    !in_en |=> $stable(in_q);
  endproperty
  a_frozen: assert property (p_frozen) else $error("pins sampled while down");
endmodule

// file: sbci_ctrl_model.sv
// Controller-side pin model: issues commands and resolves the shared data bus
`timescale 1ns/1ps
module sbci_ctrl_model (
  input wire logic clk_sys_i,
  input wire logic [31:0] dev_data_i,
  input wire logic [3:0] dev_oe_n_i,
  output logic cke_o,
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic ba0_o,
  output logic ba1_o,
  output logic [11:0] addr_o,
  output logic [3:0] mask_o,
  output logic [31:0] bus_o
);
  logic [31:0] wdata = 32'h0;
  logic drive = 1'b0;
  logic [31:0] last = 32'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // Idle pins: deselected, nop code, clock enabled
  initial begin
    {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h1F;
    {ba1_o, ba0_o, addr_o, mask_o} = 18'h0;
  end
  // All pins change together just after an edge
  task automatic put(input logic cs_n, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [3:0] m, input logic [31:0] d);
    @(posedge clk_sys_i);
    #2;
    cs_n_o = cs_n;
    {ras_n_o, cas_n_o, we_n_o} = c;
    {ba1_o, ba0_o} = b;
    addr_o = a;
    mask_o = m;
    wdata = d;
    drive = (c == 3'h4);
  endtask
  // Further beat of a write burst: data only, pins otherwise idle
  task automatic wbeat(input logic [31:0] d);
    @(posedge clk_sys_i);
    #2;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h7;
    mask_o = 4'h0;
    wdata = d;
    drive = 1'b1;
  endtask
  task automatic set_cke(input logic v);
    @(posedge clk_sys_i);
    #2;
    cke_o = v;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Undriven lanes flip every cycle so a stale value can never pass for data
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      if (!dev_oe_n_i[l]) bus_o[8*l+:8] = dev_data_i[8*l+:8];
      else if (drive) bus_o[8*l+:8] = wdata[8*l+:8];
      else bus_o[8*l+:8] = ~last[8*l+:8];
    end
  end
  always_ff @(posedge clk_sys_i) last <= bus_o;
endmodule

// file: tb_top.sv
// Self-checking bench for the SDRAM pin command interface
`timescale 1ns/1ps
module tb_top;
  import sbci_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, ba0, ba1, wbr;
  logic [11:0] addr;
  logic [3:0] mask, oe_n, eo;
  logic [31:0] bus, dout, d0, d1, ed, lm;
  logic [2:0] pm;
  logic [13:0] mreg, m;
  logic [3:0] bopen;
  logic [8:0] col;
  int fails = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] exp_d[$];
  logic [3:0] exp_oe[$];
  sbci_ctrl_model sbci_ctrl_model_i (.clk_sys_i(clk_sys_i), .dev_data_i(dout),
    .dev_oe_n_i(oe_n), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
    .we_n_o(we_n), .ba0_o(ba0), .ba1_o(ba1), .addr_o(addr), .mask_o(mask), .bus_o(bus));
  sbci_sdram_if sbci_sdram_if_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .clk_enable_pin_i(cke), .chip_sel_n_i(cs_n), .row_strobe_n_i(ras_n),
    .col_strobe_n_i(cas_n), .write_en_n_i(we_n), .bank_sel_bit0_i(ba0),
    .bank_sel_bit1_i(ba1), .row_col_address_i(addr), .byte_mask_lanes_i(mask),
    .data_bus_32_i(bus), .data_bus_32_o(dout), .data_bus_32_oe_n_o(oe_n),
    .power_mode_o(pm), .mode_reg_o(mreg), .bank_open_o(bopen), .wr_buf_ready_o(wbr));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 25 ns
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Command for one edge, then a nop carrying the given mask
  task automatic cmd(input logic cs_n_v, input logic [2:0] c, input logic [1:0] b,
                     input logic [11:0] a, input logic [3:0] m2, input logic [31:0] d);
    sbci_ctrl_model_i.put(cs_n_v, c, b, a, 4'h0, d);
    sbci_ctrl_model_i.put(1'b0, CMD_NOP, 2'h0, 12'h0, m2, 32'h0);
  endtask
  task automatic edges(input int k);
    repeat (k) @(posedge clk_sys_i);
    #2;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: every driven beat takes the oldest note; only driven lanes count
  always @(posedge clk_sys_i) begin
    #1;
    if (!reset_i && oe_n !== 4'hF) begin
      if (exp_d.size() == 0) check(32'(oe_n), 32'hF);
      else begin
        ed = exp_d.pop_front();
        eo = exp_oe.pop_front();
        lm = ~{{8{eo[3]}}, {8{eo[2]}}, {8{eo[1]}}, {8{eo[0]}}};
        check(32'(oe_n), 32'(eo));
        check(dout & lm, ed & lm);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(95577));
    edges(12);
    reset_i = 1'b0;
    check(32'({oe_n, pm, mreg, bopen, wbr}), 32'({4'hF, 3'h0, MODE_RST, 4'h0, 1'b1}));
    // Deselected activate must leave every bank closed
    cmd(1'b1, CMD_ACT, 2'h1, 12'h0, 4'h0, 32'h0);
    edges(1);
    check(32'(bopen), 32'h0);
    cmd(1'b0, CMD_ACT, 2'h1, 12'($urandom), 4'h0, 32'h0);
    edges(1);
    check(32'(bopen), 32'h2);
    col = 9'($urandom);
    d0 = $urandom;
    d1 = $urandom;
    cmd(1'b0, CMD_WR, 2'h1, {3'h0, col}, 4'h0, d0);
    edges(6);
    // Lanes 0 and 2 masked: they keep the first word
    sbci_ctrl_model_i.put(1'b0, CMD_WR, 2'h1, {3'h0, col}, 4'h5, d1);
    sbci_ctrl_model_i.put(1'b0, CMD_NOP, 2'h0, 12'h0, 4'h0, 32'h0);
    edges(6);
    ed = (d1 & 32'hFF00FF00) | (d0 & 32'h00FF00FF);
    exp_d.push_back(ed);
    exp_oe.push_back(4'h4);
    // Mask on the edge after the read floats lane 2 two edges later
    cmd(1'b0, CMD_RD, 2'h1, {3'h0, col}, 4'h4, 32'h0);
    edges(6);
    exp_d.push_back(ed);
    exp_oe.push_back(4'h0);
    cmd(1'b0, CMD_RD, 2'h1, {3'h1, col} << 0 | 12'h400, 4'h0, 32'h0);
    edges(8);
    check(32'(bopen), 32'h0);
    check(32'(exp_d.size()), 32'h0);
    cmd(1'b0, CMD_ACT, 2'h2, 12'h0, 4'h0, 32'h0);
    cmd(1'b0, CMD_ACT, 2'h3, 12'h0, 4'h0, 32'h0);
    cmd(1'b0, CMD_PRE, 2'h2, 12'h0, 4'h0, 32'h0);
    edges(1);
    check(32'(bopen), 32'h8);
    cmd(1'b0, CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
    edges(1);
    check(32'(bopen), 32'h0);
    m = {4'($urandom), 10'h032};
    cmd(1'b0, CMD_LMR, m[13:12], m[11:0], 4'h0, 32'h0);
    edges(1);
    check(32'(mreg), 32'(m));
    // Four-beat sequential burst, latency three; read from column one wraps
    cmd(1'b0, CMD_ACT, 2'h0, 12'($urandom), 4'h0, 32'h0);
    col = {col[8:2], 2'h0};
    d0 = $urandom;
    sbci_ctrl_model_i.put(1'b0, CMD_WR, 2'h0, {3'h0, col}, 4'h0, d0);
    for (int k = 1; k < 4; k++) sbci_ctrl_model_i.wbeat(d0 + 32'(k));
    edges(6);
    for (int k = 0; k < 4; k++) begin
      exp_d.push_back(d0 + 32'((k + 1) % 4));
      exp_oe.push_back(4'h0);
    end
    cmd(1'b0, CMD_RD, 2'h0, {3'h0, col | 9'h001}, 4'h0, 32'h0);
    edges(8);
    check(32'(exp_d.size()), 32'h0);
    cmd(1'b0, CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
    edges(1);
    // Idle banks give precharge power-down, an open row active power-down
    for (int i = 0; i < 2; i++) begin
      if (i == 1) cmd(1'b0, CMD_ACT, 2'h0, 12'h0, 4'h0, 32'h0);
      sbci_ctrl_model_i.set_cke(1'b0);
      edges(4);
      check(32'(pm), (i == 1) ? 32'h3 : 32'h2);
      sbci_ctrl_model_i.set_cke(1'b1);
      n = 0;
      while (pm !== 3'h0) begin
        edges(1);
        n++;
        if (n > 20) begin
          fails++;
          end_of_test();
        end
      end
      check(32'(pm), 32'h0);
    end
    cmd(1'b0, CMD_PRE, 2'h0, 12'h400, 4'h0, 32'h0);
    edges(1);
    check(32'(bopen), 32'h0);
    end_of_test();
  end
endmodule
